// File: common/acc_pkg.sv
// shared constants, types and helpers for the comparator control block
// Notes on behaviour
// [RULE_01] comparator output synchronised, one to two cycles
// [RULE_02] edge field: toggle, reserved, falling, rising
// [RULE_03] matching synchronised event sets the flag
// [RULE_04] request needs flag, enable and global enable
// [RULE_05] flag clears when the handler vectors
// [RULE_06] writing one clears flag, zero keeps it
// [RULE_07] disable bit switches comparator power off
// [RULE_08] software clears enable before changing disable
// [RULE_09] software clears enable before changing edge field
// [RULE_10] bandgap select picks positive input source
// [RULE_11] route bit feeds comparator to timer capture
// [RULE_12] software also sets timer capture interrupt enable
// [RULE_13] bandgap negative unless mux on, converter off
// [RULE_14] channel code picks negative input, two unavailable
// [RULE_15] mux enable at bit six, converter register
// [RULE_16] software clears converter power reduction first
// [RULE_17] buffer off forces port input bit zero
// [RULE_18] converter enable gates the mux selection
// [RULE_19] edges from previous cycle, none while disabled
// [RULE_20] controls reset zero, status follows synchroniser
`default_nettype none
package acc_pkg;
  // register offsets on the plain register port
  localparam int ACC_ADDR_W = 3;
  localparam logic [2:0] ACC_OFF_CONV_B = 3'h0;
  localparam logic [2:0] ACC_OFF_CMP_CS = 3'h1;
  localparam logic [2:0] ACC_OFF_DIN_DIS = 3'h2;
  localparam logic [2:0] ACC_OFF_NEG_CHAN = 3'h3;
  // field positions
  localparam int ACC_MUX_EN_BIT = 6;
  localparam int ACC_PWR_OFF_BIT = 7;
  localparam int ACC_POS_BG_BIT = 6;
  localparam int ACC_OUT_BIT = 5;
  localparam int ACC_FLAG_BIT = 4;
  localparam int ACC_IRQ_EN_BIT = 3;
  localparam int ACC_CAP_BIT = 2;
  localparam int ACC_EDGE_LO = 0;
  localparam int ACC_BUF_OFF_BIT = 0;
  // reset values
  localparam logic [7:0] ACC_RST_REG = 8'h00;
  localparam logic [2:0] ACC_RST_CHAN = 3'h0;
  // synchroniser: two stages, two asynchronous levels carried
  localparam int ACC_SYNC_W = 2;

  typedef enum logic [1:0] {
    ACC_EDGE_TOGGLE = 2'h0,
    ACC_EDGE_RSVD = 2'h1,
    ACC_EDGE_FALL = 2'h2,
    ACC_EDGE_RISE = 2'h3
  } acc_edge_t;

  // software controls of the comparator control/status register
  typedef struct packed {
    logic power_off;
    logic pos_bandgap;
    logic irq_flag;
    logic irq_enable;
    logic capture_route;
    acc_edge_t edge_sel;
  } acc_csr_t;

  // selections handed to the analog comparator core
  typedef struct packed {
    logic power_off;
    logic pos_bandgap;
    logic neg_bandgap;
    logic neg_chan_valid;
    logic [2:0] neg_chan;
  } acc_ana_t;

  // channel codes 010 and 011 have no pin behind them
  function automatic logic acc_chan_ok(input logic [2:0] code);
    acc_chan_ok = (code != 3'h2) && (code != 3'h3);
  endfunction : acc_chan_ok

  // read view of the control/status register
  function automatic logic [7:0] acc_csr_view(input acc_csr_t c,
                                              input logic out_sync);
    acc_csr_view = {c.power_off, c.pos_bandgap, out_sync, c.irq_flag,
                    c.irq_enable, c.capture_route, c.edge_sel};
  endfunction : acc_csr_view
endpackage : acc_pkg
`default_nettype wire

// File: dv/acc_ana_model.sv
// behavioural analog comparator core facing the control block
`default_nettype none
module acc_ana_model
  import acc_pkg::*;
(
  input wire logic ref_clk, // core clock, paces the model only
  input wire acc_ana_t ana_sel, // selections from the block
  input wire logic [7:0] pos_v, // level on the positive pin
  input wire logic [7:0] bg_v, // bandgap level
  input wire logic [7:0][7:0] chan_v, // converter channel levels
  output logic cmp_raw // comparator output, unsynchronised
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pos_lvl;
  logic [7:0] neg_lvl;
  logic float_neg;
  //////////////////////////////////////////////////////////////////////
  // input selection of the analog core
  always_comb begin
    pos_lvl = ana_sel.pos_bandgap ? bg_v : pos_v;
    float_neg = !ana_sel.neg_bandgap && !ana_sel.neg_chan_valid;
    neg_lvl = chan_v[ana_sel.neg_chan];
    if (ana_sel.neg_bandgap) begin
      neg_lvl = bg_v;
    end
  end
  // moves on the falling edge, away from sampling; an unpowered core or
  // a floating input gives a level that keeps flipping, never a clean 0
  initial cmp_raw = 1'b0;
  always @(negedge ref_clk) begin
    if (ana_sel.power_off || float_neg) begin
      cmp_raw <= ~cmp_raw;
    end else begin
      cmp_raw <= (pos_lvl > neg_lvl);
    end
  end
endmodule : acc_ana_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the comparator control block
`default_nettype none
module tb_top
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic resetn;
  logic [ACC_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic cmp_raw;
  logic pos_pin_raw;
  logic converter_enable;
  logic global_irq_enable;
  logic irq_vector_ack;
  logic irq_req;
  logic capture_in;
  logic pos_pin_in;
  acc_ana_t ana_sel;
  logic [7:0] pos_v;
  logic [7:0] bg_v;
  logic [7:0][7:0] chan_v;
  logic [7:0] rd_val;
  int err_count;
  int cmp_count;

  acc_top acc_top_i (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
    .pos_pin_raw(pos_pin_raw), .converter_enable(converter_enable),
    .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .irq_req(irq_req),
    .capture_in(capture_in), .pos_pin_in(pos_pin_in), .ana_sel(ana_sel));
  acc_ana_model acc_ana_model_i (.ref_clk(ref_clk), .ana_sel(ana_sel),
    .pos_v(pos_v), .bg_v(bg_v), .chan_v(chan_v), .cmp_raw(cmp_raw));

  //////////////////////////////////////////////////////////////////////
  // shared checks, bus cycles and expectations
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // sample a little after the edge so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  task automatic set_cmp(input logic b);
    @(posedge ref_clk);
    pos_v <= b ? 8'hc0 : 8'h40;
    settle(4);
  endtask : set_cmp
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  function automatic logic [7:0] reg_exp(input logic [2:0] a,
                                         input logic [7:0] d);
    case (a)
      3'h0: reg_exp = d & 8'h40;
      3'h2: reg_exp = d & 8'h01;
      3'h3: reg_exp = d & 8'h07;
      default: reg_exp = 8'h00;
    endcase
  endfunction : reg_exp
  function automatic logic flag_exp(input logic [1:0] m, input logic r);
    case (m)
      2'h0: flag_exp = 1'b1;
      2'h1: flag_exp = 1'b0;
      2'h2: flag_exp = !r;
      default: flag_exp = r;
    endcase
  endfunction : flag_exp

  //////////////////////////////////////////////////////////////////////
  // clock and watchdog; the tests need under five hundred cycles
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [2:0] a;
    logic [7:0] d;
    logic [4:0] k;
    logic [1:0] m;
    logic bg;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pos_pin_raw = 1'b0;
    converter_enable = 1'b0;
    global_irq_enable = 1'b0;
    irq_vector_ack = 1'b0;
    pos_v = 8'h40;
    bg_v = 8'h80;
    chan_v = {8{8'h20}};
    err_count = 0;
    cmp_count = 0;
    void'($urandom(61));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    settle(1);
    chk({7'h0, ana_sel.neg_bandgap}, 8'h01, "neg reset");
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      chk(rd_val, 8'h00, "reset value");
    end
    end_test("reset");
    // random data, unmapped places included
    for (int i = 0; i < 12; i++) begin
      a = 3'($urandom_range(7));
      if (a == ACC_OFF_CMP_CS) a = ACC_OFF_CONV_B;
      d = 8'($urandom);
      wr(a, d);
      rd(a);
      chk(rd_val, reg_exp(a, d), "read back");
    end
    end_test("registers");
    for (int i = 0; i < 32; i++) begin
      k = 5'(i);
      wr(ACC_OFF_CONV_B, {1'b0, k[4], 6'h0});
      wr(ACC_OFF_NEG_CHAN, {5'h0, k[2:0]});
      converter_enable <= k[3]; // power reduction cleared
      settle(1);
      bg = !k[4] || k[3];
      chk({7'h0, ana_sel.neg_bandgap}, {7'h0, bg}, "neg src");
      chk({7'h0, ana_sel.neg_chan_valid},
          {7'h0, !bg && k[2:1] != 2'h1}, "chan ok");
      if (!bg && k[2:1] != 2'h1) begin
        chk({5'h0, ana_sel.neg_chan}, {5'h0, k[2:0]}, "chan");
      end
    end
    wr(ACC_OFF_CONV_B, 8'h00);
    converter_enable <= 1'b0;
    end_test("negative input");
    wr(ACC_OFF_CMP_CS, 8'h40);
    settle(1);
    chk({7'h0, ana_sel.pos_bandgap}, 8'h01, "pos bandgap");
    wr(ACC_OFF_CMP_CS, 8'h90); // enable already off
    settle(12);
    rd(ACC_OFF_CMP_CS);
    chk(rd_val & 8'hd0, 8'h80, "off, no event");
    chk({7'h0, ana_sel.power_off}, 8'h01, "power off");
    wr(ACC_OFF_CMP_CS, 8'h00);
    settle(6);
    end_test("power and positive input");
    // enable is cleared before every mode change
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(ACC_OFF_CMP_CS, {6'h04, m});
      wr(ACC_OFF_CMP_CS, {6'h02, m});
      global_irq_enable <= 1'b0;
      set_cmp(1'b1);
      rd(ACC_OFF_CMP_CS);
      chk(rd_val, {3'h1, flag_exp(m, 1'b1), 2'h2, m}, "rise");
      chk({7'h0, irq_req}, 8'h00, "global off");
      @(posedge ref_clk);
      global_irq_enable <= 1'b1;
      settle(1);
      chk({7'h0, irq_req}, {7'h0, flag_exp(m, 1'b1)}, "irq");
      wr(ACC_OFF_CMP_CS, {6'h02, m});
      rd(ACC_OFF_CMP_CS);
      chk(rd_val, {3'h1, flag_exp(m, 1'b1), 2'h2, m}, "w0 keeps");
      wr(ACC_OFF_CMP_CS, {6'h06, m});
      rd(ACC_OFF_CMP_CS);
      chk(rd_val, {6'h0a, m}, "w1 clears");
      set_cmp(1'b0);
      rd(ACC_OFF_CMP_CS);
      chk(rd_val, {3'h0, flag_exp(m, 1'b0), 2'h2, m}, "fall");
      @(posedge ref_clk);
      irq_vector_ack <= 1'b1;
      @(posedge ref_clk);
      irq_vector_ack <= 1'b0;
      settle(1);
      chk({7'h0, irq_req}, 8'h00, "vector clears");
      wr(ACC_OFF_CMP_CS, {6'h04, m}); // enable off first
    end
    end_test("edge modes");
    wr(ACC_OFF_CMP_CS, 8'h04); // route bit set, comparator feeds timer capture
    for (int i = 0; i < 2; i++) begin
      set_cmp(i[0]);
      chk({7'h0, capture_in}, {7'h0, i[0]}, "capture");
    end
    wr(ACC_OFF_CMP_CS, 8'h00);
    settle(1);
    chk({7'h0, capture_in}, 8'h00, "no capture");
    end_test("capture route");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      @(posedge ref_clk);
      pos_pin_raw <= d[7];
      wr(ACC_OFF_DIN_DIS, {7'h0, d[0]});
      settle(3);
      chk({7'h0, pos_pin_in}, {7'h0, d[7] & !d[0]}, "pin");
    end
    end_test("pin buffer");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// File: hw/acc_edge.sv
// edge detector choosing the comparator interrupt event
`default_nettype none
module acc_edge
  import acc_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic cur, // synchronised comparator output
  input wire acc_edge_t mode, // selected event kind
  input wire logic power_off, // comparator switched off
  output logic event_hit // one-cycle pulse on a matching event
);
  logic prev;
  logic next_prev;
  logic rise;
  logic fall;

  // previous value keeps tracking while off, so no stale edge later
  always_comb begin
    next_prev = cur;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev; // [RULE_19]
    end
  end

  // compare with the previous cycle, silent while powered down
  always_comb begin
    rise = cur & ~prev; // [RULE_19]
    fall = ~cur & prev; // [RULE_19]
    case (mode)
      ACC_EDGE_TOGGLE: event_hit = (rise | fall) & ~power_off; // [RULE_02]
      ACC_EDGE_FALL: event_hit = fall & ~power_off; // [RULE_02]
      ACC_EDGE_RISE: event_hit = rise & ~power_off; // [RULE_02]
      default: event_hit = 1'b0; // reserved code raises nothing [RULE_02]
    endcase
  end
endmodule : acc_edge
`default_nettype wire

// File: hw/acc_sync.sv
// two-stage synchroniser for the asynchronous comparator and pin levels
`default_nettype none
module acc_sync
  import acc_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [ACC_SYNC_W-1:0] async_in, // levels from outside
  output logic [ACC_SYNC_W-1:0] sync_out // levels in core domain
);
  logic [ACC_SYNC_W-1:0] stage1;
  logic [ACC_SYNC_W-1:0] next_stage1;
  logic [ACC_SYNC_W-1:0] next_sync_out;

  // first stage is read only by the second stage
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1; // [RULE_01]
      sync_out <= next_sync_out; // [RULE_01]
    end
  end
endmodule : acc_sync
`default_nettype wire

// File: hw/acc_top.sv
// comparator control: registers, flag, interrupt, input routing
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  input wire logic ref_clk, // core clock, 25 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic [ACC_ADDR_W-1:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic cmp_raw, // raw comparator output, asynchronous
  input wire logic pos_pin_raw, // raw digital level of positive pin
  input wire logic converter_enable, // converter switched on
  input wire logic global_irq_enable, // core status global enable
  input wire logic irq_vector_ack, // pulse: handler vector taken
  output logic irq_req, // comparator interrupt request, level
  output logic capture_in, // comparator level to timer capture
  output logic pos_pin_in, // port input bit of the positive pin
  output acc_ana_t ana_sel // selections for the analog core
);
  ////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection
  logic [ACC_SYNC_W-1:0] sync_lv;
  logic cmp_out_sync;
  logic pin_sync;
  logic edge_event;
  acc_csr_t csr;
  acc_csr_t next_csr;
  logic neg_mux_enable;
  logic next_neg_mux_enable;
  logic pos_pin_buffer_off;
  logic next_pos_pin_buffer_off;
  logic [2:0] neg_channel_code;
  logic [2:0] next_neg_channel_code;
  logic [7:0] next_reg_rdata;
  logic wr_conv;
  logic wr_cs;
  logic wr_din;
  logic wr_chan;

  acc_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({pos_pin_raw, cmp_raw}),
    .sync_out(sync_lv)
  );

  // status bit follows the synchroniser from reset onward
  assign cmp_out_sync = sync_lv[0]; // [RULE_01] [RULE_20]
  assign pin_sync = sync_lv[1];

  acc_edge u_edge (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cur(cmp_out_sync),
    .mode(csr.edge_sel),
    .power_off(csr.power_off),
    .event_hit(edge_event)
  );

  ////////////////////////////////////////////////////////////////////
  // write decode
  always_comb begin
    wr_conv = reg_wr && (reg_addr == ACC_OFF_CONV_B);
    wr_cs = reg_wr && (reg_addr == ACC_OFF_CMP_CS);
    wr_din = reg_wr && (reg_addr == ACC_OFF_DIN_DIS);
    wr_chan = reg_wr && (reg_addr == ACC_OFF_NEG_CHAN);
  end

  // control/status next values; a new event beats any clear
  always_comb begin
    next_csr = csr;
    if (wr_cs) begin
      next_csr.power_off = reg_wdata[ACC_PWR_OFF_BIT]; // [RULE_07]
      next_csr.pos_bandgap = reg_wdata[ACC_POS_BG_BIT]; // [RULE_10]
      next_csr.irq_enable = reg_wdata[ACC_IRQ_EN_BIT]; // [RULE_04]
      next_csr.capture_route = reg_wdata[ACC_CAP_BIT]; // [RULE_11]
      next_csr.edge_sel = acc_edge_t'(reg_wdata[ACC_EDGE_LO+:2]);
      if (reg_wdata[ACC_FLAG_BIT]) begin
        next_csr.irq_flag = 1'b0; // write one clears [RULE_06]
      end
    end
    if (irq_vector_ack) begin
      next_csr.irq_flag = 1'b0; // cleared on vectoring [RULE_05]
    end
    if (edge_event) begin
      next_csr.irq_flag = 1'b1; // [RULE_03]
    end
  end

  // the other three registers hold plain control bits
  always_comb begin
    next_neg_mux_enable = neg_mux_enable;
    next_pos_pin_buffer_off = pos_pin_buffer_off;
    next_neg_channel_code = neg_channel_code;
    if (wr_conv) begin
      next_neg_mux_enable = reg_wdata[ACC_MUX_EN_BIT]; // [RULE_15]
    end
    if (wr_din) begin
      next_pos_pin_buffer_off = reg_wdata[ACC_BUF_OFF_BIT]; // [RULE_17]
    end
    if (wr_chan) begin
      next_neg_channel_code = reg_wdata[2:0];
    end
  end

  // all controls reset to zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      csr <= acc_csr_t'(ACC_RST_REG[6:0]); // [RULE_20]
      neg_mux_enable <= ACC_RST_REG[ACC_MUX_EN_BIT]; // [RULE_20]
      pos_pin_buffer_off <= ACC_RST_REG[ACC_BUF_OFF_BIT];
      neg_channel_code <= ACC_RST_CHAN;
    end else begin
      csr <= next_csr;
      neg_mux_enable <= next_neg_mux_enable;
      pos_pin_buffer_off <= next_pos_pin_buffer_off;
      neg_channel_code <= next_neg_channel_code;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path: data stands in the cycle after the strobe only
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ACC_OFF_CONV_B: next_reg_rdata[ACC_MUX_EN_BIT] = neg_mux_enable;
        ACC_OFF_CMP_CS: next_reg_rdata = acc_csr_view(csr, cmp_out_sync);
        ACC_OFF_DIN_DIS:
          next_reg_rdata[ACC_BUF_OFF_BIT] = pos_pin_buffer_off;
        ACC_OFF_NEG_CHAN: next_reg_rdata[2:0] = neg_channel_code;
        default: next_reg_rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs to core, timer, port and analog core
  // software must drop the enable before touching power or edge
  // fields, else the change itself may raise a request [RULE_08]
  // [RULE_09]
  assign irq_req = csr.irq_flag & csr.irq_enable &
                   global_irq_enable; // [RULE_04]

  // timer front end filters and picks its own edge
  assign capture_in = csr.capture_route & cmp_out_sync; // [RULE_11]

  // buffer off holds the port bit low whatever the pin does
  assign pos_pin_in = pin_sync & ~pos_pin_buffer_off; // [RULE_17]

  // the converter owns its mux while on, so the comparator loses it;
  // converter power reduction must be cleared by software [RULE_16]
  always_comb begin
    ana_sel.power_off = csr.power_off; // [RULE_07]
    ana_sel.pos_bandgap = csr.pos_bandgap; // [RULE_10]
    ana_sel.neg_bandgap = ~neg_mux_enable | converter_enable; // [RULE_13]
    ana_sel.neg_chan = neg_channel_code; // [RULE_14]
    ana_sel.neg_chan_valid = neg_mux_enable & ~converter_enable & // [RULE_18]
                             acc_chan_ok(neg_channel_code); // [RULE_14]
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking acc_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sync_latency_a: assert property ( // [RULE_01]
    ($past(resetn, 2) && $past(resetn)) |->
      cmp_out_sync == $past(cmp_raw, 2))
  else $error("comparator status not two cycles behind input");

  rise_event_a: assert property ( // [RULE_02]
    (csr.edge_sel == ACC_EDGE_RISE && !csr.power_off &&
     $rose(cmp_out_sync)) |-> edge_event)
  else $error("rising edge missed in rising mode");

  fall_mode_a: assert property ( // [RULE_02]
    (csr.edge_sel == ACC_EDGE_FALL && $rose(cmp_out_sync)) |-> !edge_event)
  else $error("rising edge raised event in falling mode");

  reserved_mode_a: assert property ( // [RULE_02]
    csr.edge_sel == ACC_EDGE_RSVD |-> !edge_event)
  else $error("reserved edge code raised an event");

  flag_set_a: assert property ( // [RULE_03]
    edge_event |=> csr.irq_flag)
  else $error("event did not set the flag");

  irq_gate_a: assert property ( // [RULE_04]
    (csr.irq_flag && csr.irq_enable && global_irq_enable) != !irq_req)
  else $error("interrupt request mismatches its gating");

  vector_clear_a: assert property ( // [RULE_05]
    (irq_vector_ack && !edge_event) |=> !csr.irq_flag)
  else $error("flag survived handler vectoring");

  sw_clear_a: assert property ( // [RULE_06]
    (wr_cs && reg_wdata[ACC_FLAG_BIT] && !edge_event) |=> !csr.irq_flag)
  else $error("writing one did not clear flag");

  sw_keep_a: assert property ( // [RULE_06]
    (wr_cs && !reg_wdata[ACC_FLAG_BIT] && csr.irq_flag &&
     !irq_vector_ack) |=> csr.irq_flag)
  else $error("writing zero disturbed the flag");

  power_write_a: assert property ( // [RULE_07]
    wr_cs |=> ana_sel.power_off == $past(reg_wdata[ACC_PWR_OFF_BIT]))
  else $error("power bit not taken from write");

  power_quiet_a: assert property ( // [RULE_19]
    csr.power_off |-> !edge_event)
  else $error("event raised while comparator is off");

  capture_route_a: assert property ( // [RULE_11]
    !csr.capture_route |-> !capture_in)
  else $error("capture path driven while unrouted");

  neg_bandgap_a: assert property ( // [RULE_13]
    (!neg_mux_enable || converter_enable) |->
      (ana_sel.neg_bandgap && !ana_sel.neg_chan_valid))
  else $error("negative input left the bandgap");

  chan_gap_a: assert property ( // [RULE_14]
    (neg_channel_code == 3'h2 || neg_channel_code == 3'h3) |->
      !ana_sel.neg_chan_valid)
  else $error("unavailable channel selected");

  pin_gate_a: assert property ( // [RULE_17]
    pos_pin_buffer_off |-> !pos_pin_in)
  else $error("port bit read high with buffer off");

  status_read_a: assert property ( // [RULE_20]
    (reg_rd && reg_addr == ACC_OFF_CMP_CS) |=>
      reg_rdata[ACC_OUT_BIT] == $past(cmp_out_sync))
  else $error("status read does not show synchronised output");

  reset_zero_a: assert property ( // [RULE_20]
    $rose(resetn) |-> (csr == '0 && !neg_mux_enable &&
                       !pos_pin_buffer_off))
  else $error("controls not zero after reset");

  toggle_event_a: assert property ( // [RULE_02]
    (csr.edge_sel == ACC_EDGE_TOGGLE && !csr.power_off &&
     $changed(cmp_out_sync)) |-> edge_event)
  else $error("toggle missed in toggle mode");

  fall_event_a: assert property ( // [RULE_02]
    (csr.edge_sel == ACC_EDGE_FALL && !csr.power_off &&
     $fell(cmp_out_sync)) |-> edge_event)
  else $error("falling edge missed in falling mode");

  rise_mode_a: assert property ( // [RULE_02]
    (csr.edge_sel == ACC_EDGE_RISE && $fell(cmp_out_sync)) |-> !edge_event)
  else $error("falling edge raised event in rising mode");

  flag_hold_a: assert property ( // [RULE_03]
    (csr.irq_flag && !irq_vector_ack &&
     !(wr_cs && reg_wdata[ACC_FLAG_BIT])) |=> csr.irq_flag)
  else $error("flag dropped without a clear");

  irq_enable_a: assert property ( // [RULE_04]
    (!csr.irq_enable || !global_irq_enable) |-> !irq_req)
  else $error("request raised while disabled");

  pos_select_a: assert property ( // [RULE_10]
    wr_cs |=> ana_sel.pos_bandgap == $past(reg_wdata[ACC_POS_BG_BIT]))
  else $error("positive source not taken from write");

  capture_follow_a: assert property ( // [RULE_11]
    csr.capture_route |-> capture_in == cmp_out_sync)
  else $error("routed capture path does not follow output");

  mux_write_a: assert property ( // [RULE_15]
    wr_conv |=> neg_mux_enable == $past(reg_wdata[ACC_MUX_EN_BIT]))
  else $error("mux enable not taken from write");

  chan_route_a: assert property ( // [RULE_18]
    (neg_mux_enable && !converter_enable &&
     neg_channel_code[2:1] != 2'h1) |->
      (ana_sel.neg_chan_valid && !ana_sel.neg_bandgap &&
       ana_sel.neg_chan == neg_channel_code))
  else $error("available channel not routed to negative input");

  pin_follow_a: assert property ( // [RULE_17]
    !pos_pin_buffer_off |-> pos_pin_in == pin_sync)
  else $error("port bit does not follow the pin");

  rise_irq_c: cover property (
    edge_event ##1 irq_req);
  vector_clear_c: cover property (
    csr.irq_flag ##1 irq_vector_ack ##1 !csr.irq_flag);
  mux_chan_c: cover property (
    ana_sel.neg_chan_valid && neg_channel_code == 3'h7);
  capture_c: cover property (
    csr.capture_route && $rose(capture_in));
  fall_event_c: cover property (
    csr.edge_sel == ACC_EDGE_FALL && edge_event);
endmodule : acc_top
`default_nettype wire
